// ==== design/pcm_pkg.sv ====
/*
  Shared constants, enumerations and state records of the current-mode pwm core.
  Assumes one 25 MHz clock; all comparator inputs arrive already synchronous to it.
*/
// ****************************************************************
// pcm_pkg: timing, modes and carriers
// ****************************************************************
package pcm_pkg;
  // clock and switching rates
  localparam int CLK_HZ = 25_000_000;
  localparam int SW_HZ = 65_000;
  localparam int JIT_HZ = 2_600;
  localparam int JIT_PERIOD_US = 4_000;
  localparam int DMAX_NUM = 3;
  localparam int DMAX_DEN = 4;
  // soft start timing
  localparam int SS_STEPS = 32;
  localparam int SS_STEP_US = 300;
  localparam int SS_TIME_MS = 10;
  // turn-on spike blanking and control-unit window
  localparam int LEB_NORM_NS = 220;
  localparam int LEB_BURST_NS = 180;
  localparam int BLANK_MS = 20;

  // derived cycle counts
  localparam int PERIOD_CYC = CLK_HZ / SW_HZ;
  localparam int JIT_DEV_CYC = PERIOD_CYC - CLK_HZ / (SW_HZ + JIT_HZ);
  localparam int JIT_STEP_CYC = (JIT_PERIOD_US * (CLK_HZ / 1_000_000)) / (4 * JIT_DEV_CYC);
  localparam int SS_STEP_CYC = SS_STEP_US * (CLK_HZ / 1_000_000);
  localparam int SS_TIME_CYC = SS_TIME_MS * (CLK_HZ / 1_000);
  localparam int BLANK_CYC = BLANK_MS * (CLK_HZ / 1_000);
  localparam int LEB_NORM_CYC = (LEB_NORM_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int LEB_BURST_CYC = (LEB_BURST_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  // widths
  localparam int CNT_W = 20;
  localparam int PER_W = 9;
  localparam int SS_W = 5;
  localparam logic [SS_W-1:0] SS_LAST = 5'(SS_STEPS - 1);
  localparam logic [PER_W-1:0] PERIOD_NOM = 9'(PERIOD_CYC);
  localparam logic signed [4:0] JIT_DEV = 5'(JIT_DEV_CYC);

  // operating modes
  typedef enum logic [2:0] {
    PCM_OFF = 3'b000,
    PCM_SOFT = 3'b001,
    PCM_RUN = 3'b010,
    PCM_BURST = 3'b011,
    PCM_RESTART = 3'b100
  } pcm_mode_e;

  // comparator results from the analog sense path
  typedef struct packed {
    logic feedback_trip;
    logic soft_start_trip;
    logic peak_limit;
    logic burst_limit;
    logic steep_slope;
  } pcm_sense_s;

  // oscillator state
  typedef struct packed {
    logic [PER_W-1:0] cnt;
    logic [PER_W-1:0] period;
    logic [PER_W-1:0] on_limit;
    logic signed [4:0] jit;
    logic up;
    logic [10:0] jtick;
    logic start;
    logic on_win;
  } pcm_osc_s;

  // core state
  typedef struct packed {
    pcm_mode_e mode;
    logic [SS_W-1:0] step;
    logic [CNT_W-1:0] ss_tick;
    logic [CNT_W-1:0] ss_time;
    logic latch;
    logic [2:0] blank;
    logic [PER_W-1:0] on_cnt;
    logic [CNT_W-1:0] burst_cnt;
    logic [CNT_W-1:0] ovl_cnt;
    logic ext_wait;
    logic fast_thr;
    logic sink;
    logic bias;
    logic burst;
    logic restart;
    logic blanking;
  } pcm_core_s;

  localparam pcm_osc_s OSC_RST = '{cnt: '0, period: 9'(PERIOD_CYC),
                                   on_limit: 9'((PERIOD_CYC * DMAX_NUM) / DMAX_DEN),
                                   jit: '0, up: 1'b1, jtick: '0, start: 1'b0, on_win: 1'b0};
  localparam pcm_core_s CORE_RST = '0;
endpackage : pcm_pkg

// ==== design/pcm_osc.sv ====
/*
  Fixed-frequency oscillator with triangular period jitter and maximum duty window.
  Assumes the parent enables jitter only in normal or burst operation.
*/
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// pcm_osc: cycle timebase
// ****************************************************************
module pcm_osc (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic jit_en_i,
  output logic cyc_start_o,
  output logic on_window_o,
  output logic [pcm_pkg::PER_W-1:0] period_o
);
  pcm_pkg::pcm_osc_s st;
  pcm_pkg::pcm_osc_s next_st;

  // on-time cap as a fraction of the period
  function automatic logic [pcm_pkg::PER_W-1:0] dmax_cycles(input logic [pcm_pkg::PER_W-1:0] p);
    logic [11:0] prod;
    prod = 12'(p) * 12'(pcm_pkg::DMAX_NUM);
    return 9'(prod / 12'(pcm_pkg::DMAX_DEN));
  endfunction : dmax_cycles

  // jitter walk, period counter, duty window
  always_comb begin
    next_st = st;
    next_st.start = 1'b0;
    if (!jit_en_i) begin
      next_st.jit = '0; // fixed frequency outside normal run and burst
      next_st.up = 1'b1;
      next_st.jtick = '0;
      next_st.period = pcm_pkg::PERIOD_NOM;
    end else if (st.jtick == 11'(pcm_pkg::JIT_STEP_CYC - 1)) begin
      next_st.jtick = '0; // triangle up and down over one jitter period
      if (st.up) begin
        if (st.jit == pcm_pkg::JIT_DEV) begin
          next_st.up = 1'b0;
          next_st.jit = st.jit - 5'sd1;
        end else begin
          next_st.jit = st.jit + 5'sd1;
        end
      end else begin
        if (st.jit == -pcm_pkg::JIT_DEV) begin
          next_st.up = 1'b1;
          next_st.jit = st.jit + 5'sd1;
        end else begin
          next_st.jit = st.jit - 5'sd1;
        end
      end
    end else begin
      next_st.jtick = st.jtick + 11'd1;
    end
    if (st.cnt >= st.period - 9'd1) begin
      next_st.cnt = '0; // new switching cycle
      next_st.start = 1'b1;
      if (jit_en_i) begin
        next_st.period = 9'(pcm_pkg::PERIOD_NOM + 9'(signed'(st.jit)));
      end
    end else begin
      next_st.cnt = st.cnt + 9'd1;
    end
    next_st.on_limit = dmax_cycles(next_st.period);
    next_st.on_win = next_st.cnt < next_st.on_limit; // duty window
  end

  // state register
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      st <= pcm_pkg::OSC_RST;
    end else begin
      st <= next_st;
    end
  end

  assign cyc_start_o = st.start;
  assign on_window_o = st.on_win;
  assign period_o = st.period;

  default clocking osc_cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  // period stays inside the jitter band
  jitter_band_a: assert property (
    st.period <= pcm_pkg::PERIOD_NOM + 9'(pcm_pkg::JIT_DEV_CYC) &&
    st.period >= pcm_pkg::PERIOD_NOM - 9'(pcm_pkg::JIT_DEV_CYC))
    else $error("oscillator period left jitter band");
endmodule : pcm_osc
`default_nettype wire

// ==== design/pcm_core.sv ====
/*
  Peak-current-mode pwm core: soft start, pulse latch, blanking, current limits,
  burst and overload windows. Instantiates the oscillator.
  Assumes supply comparators and sense comparators are synchronous levels, and that
  rst_i is driven by supply undervoltage lockout.
*/
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// pcm_core: top of the pwm block
// ****************************************************************
module pcm_core #(
  parameter int unsigned SS_STEP_CYC = pcm_pkg::SS_STEP_CYC,
  parameter int unsigned SS_TIME_CYC = pcm_pkg::SS_TIME_CYC,
  parameter int unsigned BLANK_CYC = pcm_pkg::BLANK_CYC
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic supply_on_i,
  input wire logic supply_off_i,
  input wire pcm_pkg::pcm_sense_s sense_i,
  input wire logic burst_request_i,
  input wire logic overload_i,
  input wire logic extend_enable_i,
  input wire logic extend_done_i,
  input wire logic restart_i,
  output logic gate_o,
  output logic [pcm_pkg::SS_W-1:0] soft_start_level_o,
  output logic soft_sink_on_o,
  output logic bias_on_o,
  output logic burst_active_o,
  output logic burst_limit_enable_o,
  output logic auto_restart_o,
  output logic blanking_o,
  output logic fast_threshold_o
);
  pcm_pkg::pcm_core_s st;
  pcm_pkg::pcm_core_s next_st;
  localparam int CNT_W = pcm_pkg::CNT_W;
  logic cyc_start;
  logic on_window;
  logic [pcm_pkg::PER_W-1:0] period;
  logic switching;
  logic set_req;
  logic blank_now;
  logic fb_rst;
  logic ss_rst;
  logic pk_rst;
  logic bl_rst;
  logic cap_rst;
  logic rst_req;
  logic [pcm_pkg::PER_W-1:0] on_next;
  logic [pcm_pkg::PER_W-1:0] ss_cap;

  // soft start on-time cap: step/32 of the duty window
  function automatic logic [pcm_pkg::PER_W-1:0] soft_cap(input logic [pcm_pkg::PER_W-1:0] p,
                                                         input logic [pcm_pkg::SS_W-1:0] s);
    logic [11:0] lim;
    logic [16:0] prod;
    lim = (12'(p) * 12'(pcm_pkg::DMAX_NUM)) / 12'(pcm_pkg::DMAX_DEN);
    prod = 17'(lim) * 17'(s);
    return 9'(prod >> pcm_pkg::SS_W);
  endfunction : soft_cap

  // ****************************************************************
  // oscillator
  // ****************************************************************
  pcm_osc u_osc (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .jit_en_i(st.mode == pcm_pkg::PCM_RUN || st.mode == pcm_pkg::PCM_BURST),
    .cyc_start_o(cyc_start),
    .on_window_o(on_window),
    .period_o(period)
  );

  // ****************************************************************
  // pulse latch and its reset sources
  // ****************************************************************
  // latch requests from oscillator and comparators
  always_comb begin
    switching = (st.mode == pcm_pkg::PCM_SOFT || st.mode == pcm_pkg::PCM_RUN ||
                 st.mode == pcm_pkg::PCM_BURST) && !supply_off_i;
    set_req = cyc_start && switching;
    blank_now = set_req || (st.blank != 3'd0);
    fb_rst = !blank_now && sense_i.feedback_trip;
    ss_rst = !blank_now && sense_i.soft_start_trip && (st.mode == pcm_pkg::PCM_SOFT);
    pk_rst = !blank_now && sense_i.peak_limit;
    bl_rst = !blank_now && sense_i.burst_limit && (st.mode == pcm_pkg::PCM_BURST);
    on_next = set_req ? 9'd0 : (st.latch ? st.on_cnt + 9'd1 : st.on_cnt);
    ss_cap = soft_cap(period, st.step);
    cap_rst = (st.mode == pcm_pkg::PCM_SOFT) && (on_next >= ss_cap);
    rst_req = fb_rst || ss_rst || pk_rst || bl_rst || cap_rst || !on_window || !switching;
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  // modes, soft start counters, control-unit windows
  always_comb begin
    next_st = st;
    next_st.latch = (st.latch || set_req) && !rst_req;
    next_st.on_cnt = on_next;
    next_st.fast_thr = sense_i.steep_slope;
    if (set_req) begin
      next_st.blank = (st.mode == pcm_pkg::PCM_BURST) ? 3'(pcm_pkg::LEB_BURST_CYC)
                                                      : 3'(pcm_pkg::LEB_NORM_CYC);
    end else if (st.blank != 3'd0) begin
      next_st.blank = st.blank - 3'd1;
    end
    unique case (st.mode)
      pcm_pkg::PCM_OFF: begin
        if (supply_on_i) begin
          next_st.mode = pcm_pkg::PCM_SOFT;
          next_st.step = '0;
          next_st.ss_tick = '0;
          next_st.ss_time = '0;
        end
      end
      pcm_pkg::PCM_SOFT: begin
        if (st.ss_tick == CNT_W'(SS_STEP_CYC - 1)) begin
          next_st.ss_tick = '0;
          if (st.step != pcm_pkg::SS_LAST) begin
            next_st.step = st.step + 5'd1;
          end
        end else begin
          next_st.ss_tick = st.ss_tick + 20'd1;
        end
        if (st.ss_time == CNT_W'(SS_TIME_CYC - 1)) begin
          next_st.mode = pcm_pkg::PCM_RUN;
        end else begin
          next_st.ss_time = st.ss_time + 20'd1;
        end
      end
      pcm_pkg::PCM_RUN: begin
        if (overload_i) begin
          next_st.burst_cnt = '0;
          if (st.ovl_cnt != CNT_W'(BLANK_CYC - 1)) begin
            next_st.ovl_cnt = st.ovl_cnt + 20'd1;
          end else if (extend_enable_i && !extend_done_i) begin
            next_st.ext_wait = 1'b1;
          end else begin
            next_st.mode = pcm_pkg::PCM_RESTART;
            next_st.ovl_cnt = '0;
            next_st.ext_wait = 1'b0;
          end
        end else begin
          next_st.ovl_cnt = '0;
          next_st.ext_wait = 1'b0;
          if (!burst_request_i) begin
            next_st.burst_cnt = '0;
          end else if (st.burst_cnt != CNT_W'(BLANK_CYC - 1)) begin
            next_st.burst_cnt = st.burst_cnt + 20'd1;
          end else begin
            next_st.mode = pcm_pkg::PCM_BURST;
            next_st.burst_cnt = '0;
          end
        end
      end
      pcm_pkg::PCM_BURST: begin
        if (!burst_request_i) begin
          next_st.mode = pcm_pkg::PCM_RUN;
        end
      end
      pcm_pkg::PCM_RESTART: begin
        if (restart_i) begin
          next_st.mode = pcm_pkg::PCM_SOFT;
          next_st.step = '0;
          next_st.ss_tick = '0;
          next_st.ss_time = '0;
        end
      end
      default: begin
        next_st.mode = pcm_pkg::PCM_OFF;
      end
    endcase
    // supply turn-off overrides everything
    if (supply_off_i) begin
      next_st.mode = pcm_pkg::PCM_OFF;
      next_st.step = '0;
      next_st.ss_tick = '0;
      next_st.ss_time = '0;
      next_st.burst_cnt = '0;
      next_st.ovl_cnt = '0;
      next_st.ext_wait = 1'b0;
    end
    // registered output flags
    next_st.sink = next_st.mode == pcm_pkg::PCM_SOFT;
    next_st.bias = next_st.mode == pcm_pkg::PCM_SOFT || next_st.mode == pcm_pkg::PCM_RUN;
    next_st.burst = next_st.mode == pcm_pkg::PCM_BURST;
    next_st.restart = next_st.mode == pcm_pkg::PCM_RESTART;
    next_st.blanking = next_st.blank != 3'd0;
  end

  // state register
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      st <= pcm_pkg::CORE_RST;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from state
  assign gate_o = st.latch;
  assign soft_start_level_o = st.step;
  assign soft_sink_on_o = st.sink;
  assign bias_on_o = st.bias;
  assign burst_active_o = st.burst;
  assign burst_limit_enable_o = st.burst;
  assign auto_restart_o = st.restart;
  assign blanking_o = st.blanking;
  assign fast_threshold_o = st.fast_thr;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking core_cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  sequence blank_norm_s;
    blanking_o [*6] ##1 !blanking_o;
  endsequence
  sequence blank_burst_s;
    blanking_o [*5] ##1 !blanking_o;
  endsequence

  fb_trip_off_a: assert property (st.latch && !blank_now &&
    sense_i.feedback_trip |=> !gate_o)
    else $error("feedback trip did not end pulse");
  ss_start_a: assert property (st.mode == pcm_pkg::PCM_OFF && supply_on_i &&
    !supply_off_i |=> soft_sink_on_o && soft_start_level_o == 5'd0)
    else $error("soft start not begun at turn-on");
  ss_step_a: assert property (st.mode == pcm_pkg::PCM_SOFT && !supply_off_i &&
    st.ss_tick == CNT_W'(SS_STEP_CYC - 1) && st.step != pcm_pkg::SS_LAST
    |=> soft_start_level_o == $past(soft_start_level_o) + 5'd1)
    else $error("soft start step missed");
  ss_done_a: assert property (st.mode == pcm_pkg::PCM_SOFT && !supply_off_i &&
    st.ss_time == CNT_W'(SS_TIME_CYC - 1) |=> !soft_sink_on_o && bias_on_o)
    else $error("soft start did not finish");
  ss_zero_duty_a: assert property (soft_sink_on_o &&
    soft_start_level_o == 5'd0 |-> !gate_o)
    else $error("gate on at soft start step zero");
  restart_ss_a: assert property (auto_restart_o && restart_i && !supply_off_i
    |=> soft_sink_on_o && soft_start_level_o == 5'd0 && !gate_o)
    else $error("restart did not rerun soft start");
  dmax_off_a: assert property (!on_window |=> !gate_o)
    else $error("gate on beyond duty limit");
  fixed_freq_a: assert property (soft_sink_on_o |-> period == pcm_pkg::PERIOD_NOM)
    else $error("frequency jittered in soft start");
  reset_wins_a: assert property (set_req && rst_req |=> !gate_o)
    else $error("set beat reset in latch");
  peak_limit_a: assert property (!blank_now && sense_i.peak_limit |=> !gate_o)
    else $error("peak limit did not clear latch");
  uvlo_gate_a: assert property (supply_off_i
    |=> !gate_o && !bias_on_o && soft_start_level_o == 5'd0)
    else $error("gate or bias on under undervoltage");
  blank_norm_a: assert property ($rose(gate_o) &&
    !$past(burst_active_o) |-> blank_norm_s)
    else $error("normal blanking length wrong");
  blank_burst_a: assert property ($rose(gate_o) &&
    $past(burst_active_o) |-> blank_burst_s)
    else $error("burst blanking length wrong");
  burst_entry_a: assert property ($rose(burst_active_o)
    |-> $past(st.burst_cnt) == CNT_W'(BLANK_CYC - 1))
    else $error("burst entered before window");

  // comparator paths that end the pulse
  ss_trip_off_a: assert property (st.latch && !blank_now &&
    sense_i.soft_start_trip && soft_sink_on_o |=> !gate_o)
    else $error("soft start trip did not end pulse");
  burst_limit_a: assert property (st.latch && !blank_now &&
    sense_i.burst_limit && burst_active_o |=> !gate_o)
    else $error("burst limit did not end pulse");

  // set path, restart hold-off and forwarded slope
  gate_set_a: assert property (set_req && !rst_req |=> gate_o && blanking_o)
    else $error("oscillator start did not set latch");
  restart_gate_a: assert property (auto_restart_o |=> !gate_o)
    else $error("gate on in auto restart");
  fast_thr_a: assert property (!$past(rst_i) |->
    fast_threshold_o == $past(sense_i.steep_slope))
    else $error("slope flag not forwarded");

  // overload window before auto restart
  overload_entry_a: assert property ($rose(auto_restart_o)
    |-> $past(st.ovl_cnt) == CNT_W'(BLANK_CYC - 1))
    else $error("auto restart entered before window");
endmodule : pcm_core
`default_nettype wire

// ==== dv/pcm_switch_model.sv ====
/*
  Far-side model: power switch, sense resistor and comparators on the sense path.
  Assumes the bench picks which comparator trips and after how many on-cycles.
*/
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// pcm_switch_model: current ramp and comparator trips
// ****************************************************************
module pcm_switch_model (
  input wire logic mclk_i,
  input wire logic gate_i,
  input wire logic trip_en_i,
  input wire logic [1:0] trip_sel_i,
  input wire logic [15:0] trip_after_i,
  input wire logic steep_i,
  output var pcm_pkg::pcm_sense_s sense_o
);
  logic [15:0] ramp = 16'h0000;
  logic hit;

  // primary current rises only while the switch conducts
  always @(posedge mclk_i) begin
    ramp <= gate_i ? ramp + 16'h0001 : 16'h0000;
  end

  // no current once the switch is off, so the four trip comparators fall; the slope flag is passed through
  always_comb begin
    hit = trip_en_i && gate_i && (ramp >= trip_after_i);
    sense_o = '0;
    sense_o.feedback_trip = hit && (trip_sel_i == 2'h0);
    sense_o.soft_start_trip = hit && (trip_sel_i == 2'h1);
    sense_o.peak_limit = hit && (trip_sel_i == 2'h2);
    sense_o.burst_limit = hit && (trip_sel_i == 2'h3);
    sense_o.steep_slope = steep_i;
  end
endmodule : pcm_switch_model
`default_nettype wire

// ==== dv/tb_pcm_core.sv ====
/*
  Self-checking bench of the pwm core against integer timing expectations.
  Assumes the design package and the switch model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// tb_pcm_core: scenarios and verdict
// ****************************************************************
module tb_pcm_core;
  localparam int SSC = 20;
  localparam int SST = 1600;
  localparam int BLC = 50;
  logic mclk_i = 1'h0;
  logic rst_i = 1'h1;
  logic supply_on_i = 1'h0;
  logic supply_off_i = 1'h0;
  logic burst_request_i = 1'h0;
  logic overload_i = 1'h0;
  logic extend_enable_i = 1'h0;
  logic extend_done_i = 1'h0;
  logic restart_i = 1'h0;
  logic trip_en = 1'h0;
  logic [1:0] trip_sel = 2'h0;
  logic [15:0] trip_after = 16'h0000;
  logic steep = 1'h0;
  logic steep_d = 1'h0;
  logic gate_d = 1'h0;
  logic [4:0] lvl_d = 5'h00;
  pcm_pkg::pcm_sense_s sense_i;
  logic gate_o, soft_sink_on_o, bias_on_o, burst_active_o, burst_limit_enable_o;
  logic auto_restart_o, blanking_o, fast_threshold_o;
  logic [pcm_pkg::SS_W-1:0] soft_start_level_o;
  int mismatches = 0;
  int tests_run = 0;
  int seed = 60397;
  int cyc = 0;
  int rise_t = 0, hi = 0, bl = 0, step_t = 0, n = 0, k = 0, ta = 0, lo = 0, up = 0;
  int pw_q[$], per_q[$], bl_q[$], lv_q[$], st_q[$];

  pcm_core #(.SS_STEP_CYC(SSC), .SS_TIME_CYC(SST), .BLANK_CYC(BLC)) dut (
    .mclk_i(mclk_i), .rst_i(rst_i), .supply_on_i(supply_on_i),
    .supply_off_i(supply_off_i), .sense_i(sense_i), .burst_request_i(burst_request_i),
    .overload_i(overload_i), .extend_enable_i(extend_enable_i),
    .extend_done_i(extend_done_i), .restart_i(restart_i), .gate_o(gate_o),
    .soft_start_level_o(soft_start_level_o), .soft_sink_on_o(soft_sink_on_o),
    .bias_on_o(bias_on_o), .burst_active_o(burst_active_o),
    .burst_limit_enable_o(burst_limit_enable_o), .auto_restart_o(auto_restart_o),
    .blanking_o(blanking_o), .fast_threshold_o(fast_threshold_o)
  );

  pcm_switch_model sw (
    .mclk_i(mclk_i), .gate_i(gate_o), .trip_en_i(trip_en), .trip_sel_i(trip_sel),
    .trip_after_i(trip_after), .steep_i(steep), .sense_o(sense_i)
  );

  // clock
  always #20 mclk_i = ~mclk_i;

  // random slope flag once out of reset
  always @(posedge mclk_i) begin
    steep <= rst_i ? 1'h0 : 1'($random(seed));
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  function automatic logic [31:0] inr(input int v, input int a, input int b);
    return {31'h0000_0000, (v >= a) && (v <= b)};
  endfunction : inr

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // pulse widths, periods, blanking lengths and step spacing seen at the ports
  always @(posedge mclk_i) begin
    cyc = cyc + 1;
    if (!rst_i) check("fast threshold", fast_threshold_o, steep_d);
    steep_d = steep;
    if (gate_o) hi = hi + 1;
    if (blanking_o) bl = bl + 1;
    if (gate_o && !gate_d) begin
      per_q.push_back(cyc - rise_t);
      rise_t = cyc;
    end
    if (!gate_o && gate_d) begin
      pw_q.push_back(hi);
      lv_q.push_back(soft_start_level_o);
      hi = 0;
    end
    if (!blanking_o && bl != 0) begin
      bl_q.push_back(bl);
      bl = 0;
    end
    if (soft_start_level_o != lvl_d) begin
      if (lvl_d != 0 && soft_start_level_o != 0) st_q.push_back(cyc - step_t);
      step_t = cyc;
    end
    lvl_d = soft_start_level_o;
    gate_d = gate_o;
    if (cyc == 60000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  task automatic clear_q();
    pw_q.delete();
    per_q.delete();
    bl_q.delete();
    lv_q.delete();
    st_q.delete();
  endtask : clear_q

  // main sequence
  initial begin
    repeat (10) @(posedge mclk_i);
    rst_i <= 1'h0;
    repeat (500) @(posedge mclk_i);
    check("idle pulses", pw_q.size() + per_q.size(), 0);
    check("idle bias", bias_on_o, 1'h0);
    $display("test idle done");
    supply_on_i <= 1'h1;
    repeat (3) @(posedge mclk_i);
    check("sink on", soft_sink_on_o, 1'h1);
    check("bias on", bias_on_o, 1'h1);
    n = 3;
    while (soft_sink_on_o === 1'h1 && n < 2000) begin
      @(posedge mclk_i);
      n++;
    end
    check("soft length", inr(n, SST - 2, SST + 2), 1);
    check("step count", st_q.size(), 30);
    foreach (st_q[i]) check("step spacing", st_q[i], SSC);
    foreach (pw_q[i]) check("soft width", inr(pw_q[i], 1, 9 * lv_q[i] + 2), 1);
    for (int i = 1; i < per_q.size(); i++) check("soft period", per_q[i], 384);
    $display("test soft start done");
    clear_q();
    repeat (12000) @(posedge mclk_i);
    k = 0;
    foreach (pw_q[i]) check("max width", inr(pw_q[i], 270, 301), 1);
    foreach (per_q[i]) begin
      check("run period", inr(per_q[i], 369, 399), 1);
      if (per_q[i] != 384) k++;
    end
    check("jitter seen", inr(k, 1, 100000), 1);
    foreach (bl_q[i]) check("normal blank", bl_q[i], 6);
    $display("test run done");
    // random trips, then a trip held from turn-on, then burst limit outside burst
    for (int i = 0; i < 10; i++) begin
      ta = (i < 8) ? 8 + ($random(seed) & 127) : ((i == 8) ? 0 : 10);
      lo = (i < 8) ? ta : ((i == 8) ? 6 : 270);
      up = (i < 8) ? ta + 2 : ((i == 8) ? 9 : 301);
      trip_after <= 16'(ta);
      trip_sel <= (i == 9) ? 2'h3 : (i[0] ? 2'h2 : 2'h0);
      trip_en <= 1'h1;
      @(posedge mclk_i);
      clear_q();
      n = 0;
      while (pw_q.size() < 2 && n < 1000) begin
        @(posedge mclk_i);
        n++;
      end
      check("trip width", inr(pw_q[$], lo, up), 1);
    end
    trip_en <= 1'h0;
    $display("test trips done");
    burst_request_i <= 1'h1;
    repeat (30) @(posedge mclk_i);
    burst_request_i <= 1'h0;
    repeat (60) @(posedge mclk_i);
    check("short burst request", burst_active_o, 1'h0);
    burst_request_i <= 1'h1;
    n = 0;
    while (burst_active_o !== 1'h1 && n < 200) begin
      @(posedge mclk_i);
      n++;
    end
    check("burst delay", inr(n, BLC - 2, BLC + 3), 1);
    check("burst gate", burst_limit_enable_o, 1'h1);
    trip_after <= 16'h0014;
    trip_sel <= 2'h3;
    trip_en <= 1'h1;
    @(posedge mclk_i);
    clear_q();
    n = 0;
    while (pw_q.size() < 2 && n < 3000) begin
      @(posedge mclk_i);
      n++;
    end
    check("burst blank", bl_q[$], 5);
    check("burst width", inr(pw_q[$], 20, 22), 1);
    burst_request_i <= 1'h0;
    trip_en <= 1'h0;
    repeat (5) @(posedge mclk_i);
    check("burst exit", burst_active_o, 1'h0);
    $display("test burst done");
    extend_enable_i <= 1'h1;
    overload_i <= 1'h1;
    repeat (120) @(posedge mclk_i);
    check("extended wait", auto_restart_o, 1'h0);
    extend_done_i <= 1'h1;
    repeat (4) @(posedge mclk_i);
    check("extended restart", auto_restart_o, 1'h1);
    overload_i <= 1'h0;
    extend_enable_i <= 1'h0;
    extend_done_i <= 1'h0;
    restart_i <= 1'h1;
    @(posedge mclk_i);
    restart_i <= 1'h0;
    repeat (3) @(posedge mclk_i);
    check("restart soft", soft_sink_on_o, 1'h1);
    check("restart step", soft_start_level_o, 5'h00);
    // soft start comparator trips at ramp 8: every soft pulse is 9 cycles
    trip_after <= 16'h0008;
    trip_sel <= 2'h1;
    trip_en <= 1'h1;
    clear_q();
    n = 0;
    while (soft_sink_on_o === 1'h1 && n < 2000) begin
      @(posedge mclk_i);
      n++;
    end
    check("soft trip count", inr(pw_q.size(), 3, 5), 1);
    foreach (pw_q[i]) check("soft trip width", pw_q[i], 9);
    trip_en <= 1'h0;
    overload_i <= 1'h1;
    n = 0;
    while (auto_restart_o !== 1'h1 && n < 200) begin
      @(posedge mclk_i);
      n++;
    end
    check("overload delay", inr(n, BLC - 2, BLC + 3), 1);
    overload_i <= 1'h0;
    restart_i <= 1'h1;
    @(posedge mclk_i);
    restart_i <= 1'h0;
    repeat (300) @(posedge mclk_i);
    check("step advanced", inr(soft_start_level_o, 1, 31), 1);
    supply_off_i <= 1'h1;
    repeat (3) @(posedge mclk_i);
    check("off gate", gate_o, 1'h0);
    check("off bias", bias_on_o, 1'h0);
    check("off step", soft_start_level_o, 5'h00);
    $display("test restart and turn-off done");
    tally_and_finish();
  end
endmodule : tb_pcm_core
`default_nettype wire
